//--- common/iobc_map.svh
// Purpose: register offsets, field positions and reset values of the I/O bus controller
// Assumes: 32-bit AXI4-Lite register window, byte addressed
// Notes:   definitions only
`ifndef IOBC_MAP_SVH
`define IOBC_MAP_SVH

// ==========================================================
// register offsets
`define IOBC_OFF_CTRL      8'h00
`define IOBC_OFF_TIMEOUT   8'h04
`define IOBC_OFF_STATUS    8'h08
`define IOBC_OFF_COUNT     8'h0c

// ==========================================================
// control fields
`define IOBC_CTRL_SEL_LSB  0
`define IOBC_CTRL_SEL_MSB  2
`define IOBC_CTRL_SRC_BIT  3
`define IOBC_CTRL_DOFF_BIT 4
`define IOBC_CTRL_REC_LSB  8
`define IOBC_CTRL_REC_MSB  15
`define IOBC_CTRL_RST      32'h0000_0200
`define IOBC_TMO_RST       32'h0000_0100
`define IOBC_TMO_MSB       15

// ==========================================================
// status fields
`define IOBC_ST_VALID_BIT  0
`define IOBC_ST_RECOVERY_HOLD_BIT  1
`define IOBC_ST_TMO_BIT    2
`define IOBC_ST_CNT_LSB    4
`define IOBC_ST_CNT_MSB    6
`define IOBC_ST_SEL_LSB    8
`define IOBC_ST_SEL_MSB    10

// ==========================================================
// bus answers and decode constants
`define IOBC_RESP_OKAY     2'b00
`define IOBC_RESP_SLVERR   2'b10
`define IOBC_DEC_BLOCK     3'h7
`define IOBC_SEL_ZERO      3'h0

`endif

//--- common/iobc_pkg.sv
// Purpose: shared types of the I/O bus controller
// Assumes: map header holds all numbers
// Notes:   status lines travel together as one struct
package iobc_pkg;

	// ==========================================================
	// processor cycle status lines, valid with the address strobe
	typedef struct packed {
		logic mem_io_n;      // low selects I/O space
		logic data_ctrl_n;   // high selects a data cycle
		logic write_read_n;  // high write, low read
	} iobc_status_t;

	// ==========================================================
	// bus cycle sequencer states
	typedef enum logic [2:0] {
		IOBC_IDLE = 3'b001,
		IOBC_HOLD = 3'b010,
		IOBC_RUN  = 3'b100
	} iobc_state_t;

endpackage : iobc_pkg

//--- logic/iobc_top.sv
// Purpose: I/O bus control, wait states, address decode and transceiver control
// Assumes: processor bus synchronous to clk_sys; wait select pins are asynchronous
// Notes:   registers reached over AXI4-Lite; all outputs come from flip-flops
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "iobc_map.svh"

module iobc_top
	import iobc_pkg::*;
#(
	parameter int SEL_W = 3,   // wait select width
	parameter int NSEL  = 8    // decoder outputs, 2^3
) (
	input  wire logic               clk_sys,               // system clock
	input  wire logic               rst,                   // async reset, high
	input  wire logic [7:0]         s_axi_awaddr,          // write address
	input  wire logic               s_axi_awvalid,         // write address valid
	output logic                    s_axi_awready,         // write address ready
	input  wire logic [31:0]        s_axi_wdata,           // write data
	input  wire logic [3:0]         s_axi_wstrb,           // write byte lanes
	input  wire logic               s_axi_wvalid,          // write data valid
	output logic                    s_axi_wready,          // write data ready
	output logic [1:0]              s_axi_bresp,           // write response
	output logic                    s_axi_bvalid,          // write response valid
	input  wire logic               s_axi_bready,          // write response ready
	input  wire logic [7:0]         s_axi_araddr,          // read address
	input  wire logic               s_axi_arvalid,         // read address valid
	output logic                    s_axi_arready,         // read address ready
	output logic [31:0]             s_axi_rdata,           // read data
	output logic [1:0]              s_axi_rresp,           // read response
	output logic                    s_axi_rvalid,          // read data valid
	input  wire logic               s_axi_rready,          // read data ready
	input  wire logic               addr_strobe_n,         // cycle start, low
	input  wire iobc_status_t       cycle_status,          // cycle type lines
	input  wire logic [7:2]         io_addr,               // decoded address bits
	input  wire logic [3:0]         byte_enables_n,        // byte lanes, low
	input  wire logic [SEL_W-1:0]   wait_count_select,     // wait select pins
	output logic                    cpu_ready_n,           // ready to processor
	output logic                    io_cycle_valid,        // I/O cycle under way
	output logic                    io_read_strobe_n,      // I/O read, low
	output logic                    io_write_strobe_n,     // I/O write, low
	output logic [SEL_W-1:0]        wait_counter_bits,     // wait counter
	output logic                    recovery_hold,         // recovery in progress
	output logic                    xcvr_direction,        // high write direction
	output logic                    xcvr_output_enable_n,  // transceiver on, low
	output logic                    decoder_enable_low_a,  // I/O space enable
	output logic                    decoder_enable_high,   // block enable
	output logic                    decoder_enable_low_b,  // data cycle enable
	output logic [NSEL-1:0]         io_select_n            // block selects, low
);

	// ==========================================================
	// state
	iobc_state_t       state_q, state_d;
	logic              valid_q, rdy_n_q, rd_n_q, wr_n_q;
	logic [SEL_W-1:0]  cnt_q, cnt_d, cyc_sel_q, sel_s1_q, sel_s2_q;
	logic [7:0]        rec_cnt_q, rec_cnt_d;
	logic              rec_q, dir_q, den_n_q;
	logic              dla_q, dhi_q, dlb_q;
	logic [NSEL-1:0]   sel_n_q;
	logic [15:0]       tmo_cnt_q, cyc_done_q;
	logic              tmo_flag_q, st_clr;
	logic [31:0]       ctrl_q, tmo_lim_q;
	logic              awr_q, wr_q_rdy, bv_q, arr_q, rv_q;
	logic              aw_hold_q, w_hold_q;
	logic [7:0]        aw_addr_q;
	logic [31:0]       w_data_q, rdata_q;
	logic [3:0]        w_strb_q;
	logic [1:0]        bresp_q, rresp_q;

	// ==========================================================
	// wait select source: synchronised pins or software value
	wire [SEL_W-1:0] sel_sw   = ctrl_q[`IOBC_CTRL_SEL_MSB:`IOBC_CTRL_SEL_LSB];
	wire             sel_soft = ctrl_q[`IOBC_CTRL_SRC_BIT];
	wire [SEL_W-1:0] sel_eff  = sel_soft ? sel_sw : sel_s2_q;
	wire             dec_off  = ctrl_q[`IOBC_CTRL_DOFF_BIT];
	wire [7:0]       rec_len  = ctrl_q[`IOBC_CTRL_REC_MSB:`IOBC_CTRL_REC_LSB];
	wire [15:0]      tmo_lim  = tmo_lim_q[`IOBC_TMO_MSB:0];

	// pin synchroniser, first stage read only by the second
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sel_s1_q <= '0;
			sel_s2_q <= '0;
		end else begin
			sel_s1_q <= wait_count_select;
			sel_s2_q <= sel_s1_q;
		end
	end

	// ==========================================================
	// cycle decode and sequencing terms
	wire io_start  = !addr_strobe_n && !cycle_status.mem_io_n
		&& cycle_status.data_ctrl_n;
	wire in_idle   = (state_q == IOBC_IDLE);
	wire in_hold   = (state_q == IOBC_HOLD);
	wire in_run    = (state_q == IOBC_RUN);
	wire take      = in_idle && io_start;
	wire cyc_end   = in_run && !rdy_n_q;
	wire tmo_hit   = (in_hold || (in_run && rdy_n_q)) && (tmo_lim != 16'h0000)
		&& (tmo_cnt_q >= tmo_lim);
	wire hold_next = (rec_cnt_d != 8'h00);
	wire [SEL_W-1:0] cyc_sel  = take ? sel_eff : cyc_sel_q;
	wire [SEL_W-1:0] cnt_inc  = cnt_q + 3'h1;
	wire strobe_go = (take || in_hold) && !hold_next;

	// recovery counter loads at the edge that ends an access
	always_comb begin
		if (cyc_end)
			rec_cnt_d = rec_len;
		else if (rec_cnt_q != 8'h00)
			rec_cnt_d = rec_cnt_q - 8'h01;
		else
			rec_cnt_d = 8'h00;
	end

	// next state and wait counter
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			IOBC_IDLE: begin
				if (take)
					state_d = hold_next ? IOBC_HOLD : IOBC_RUN;
				cnt_d = `IOBC_SEL_ZERO;
			end
			IOBC_HOLD: begin
				if (!hold_next || tmo_hit)
					state_d = IOBC_RUN;
				cnt_d = `IOBC_SEL_ZERO;
			end
			IOBC_RUN: begin
				if (cyc_end) begin
					state_d = IOBC_IDLE;
					cnt_d   = `IOBC_SEL_ZERO;
				end else begin
					cnt_d = cnt_inc;
				end
			end
		endcase
	end

	// sequencer registers: valid, ready, strobes, counter
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q   <= IOBC_IDLE;
			valid_q   <= 1'b0;
			rdy_n_q   <= 1'b1;
			rd_n_q    <= 1'b1;
			wr_n_q    <= 1'b1;
			cnt_q     <= '0;
			cyc_sel_q <= '0;
			rec_cnt_q <= 8'h00;
			rec_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			cyc_sel_q <= cyc_sel;
			rec_cnt_q <= rec_cnt_d;
			rec_q     <= hold_next;
			if (take)
				valid_q <= 1'b1;
			else if (cyc_end)
				valid_q <= 1'b0;
			// ready: low in the clock the counter meets the select
			if (cyc_end)
				rdy_n_q <= 1'b1;
			else if (tmo_hit)
				rdy_n_q <= 1'b0;
			else if (strobe_go)
				rdy_n_q <= (cyc_sel != `IOBC_SEL_ZERO);
			else if (in_run)
				rdy_n_q <= (cnt_inc != cyc_sel_q);
			// strobes: on in the second clock, or once the recovery count runs out after a hold, off at the ending edge
			if (cyc_end) begin
				rd_n_q <= 1'b1;
				wr_n_q <= 1'b1;
			end else if (strobe_go) begin
				rd_n_q <= cycle_status.write_read_n;
				wr_n_q <= !cycle_status.write_read_n;
			end
		end
	end

	// ==========================================================
	// address decoder enables and selects
	wire dhi_d = (dec_off || tmo_hit) ? 1'b0
		: take ? (io_addr[7:5] == `IOBC_DEC_BLOCK)
		: cyc_end ? 1'b0 : dhi_q;
	wire dla_d = (dec_off || tmo_hit) ? 1'b1
		: take ? cycle_status.mem_io_n : cyc_end ? 1'b1 : dla_q;
	wire dlb_d = (dec_off || tmo_hit) ? 1'b1
		: take ? !cycle_status.data_ctrl_n : cyc_end ? 1'b1 : dlb_q;
	wire dec_on = !dla_d && dhi_d && !dlb_d;
	logic [NSEL-1:0] sel_n_d;

	// one select per block from live A2..A4; A8..A15 never reach here
	genvar gi;
	generate
		for (gi = 0; gi < NSEL; gi++) begin : g_sel
			assign sel_n_d[gi] = !(dec_on && (io_addr[4:2] == 3'(gi)));
		end
	endgenerate

	// decoder, direction and transceiver enable registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dhi_q   <= 1'b0;
			dla_q   <= 1'b1;
			dlb_q   <= 1'b1;
			sel_n_q <= '1;
			dir_q   <= 1'b0;
			den_n_q <= 1'b1;
		end else begin
			dhi_q   <= dhi_d;
			dla_q   <= dla_d;
			dlb_q   <= dlb_d;
			sel_n_q <= sel_n_d;
			if (take)
				dir_q <= cycle_status.write_read_n;
			den_n_q <= !((take || (valid_q && !cyc_end))
				&& (byte_enables_n != 4'hf));
		end
	end

	// ==========================================================
	// timeout and statistics
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tmo_cnt_q  <= 16'h0000;
			tmo_flag_q <= 1'b0;
			cyc_done_q <= 16'h0000;
		end else begin
			tmo_cnt_q <= (in_idle || cyc_end) ? 16'h0000 : tmo_cnt_q + 16'h0001;
			if (tmo_hit)
				tmo_flag_q <= 1'b1;                                  // set beats clear
			else if (st_clr)
				tmo_flag_q <= 1'b0;
			if (cyc_end)
				cyc_done_q <= cyc_done_q + 16'h0001;
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	wire aw_fire = s_axi_awvalid && awr_q;
	wire w_fire  = s_axi_wvalid && wr_q_rdy;
	wire do_wr   = aw_hold_q && w_hold_q && !bv_q;
	wire ar_fire = s_axi_arvalid && arr_q;
	logic [31:0] wmask;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{w_strb_q[gi]}};
		end
	endgenerate
	wire hit_ctrl = (aw_addr_q == `IOBC_OFF_CTRL);
	wire hit_tmo  = (aw_addr_q == `IOBC_OFF_TIMEOUT);
	wire hit_st   = (aw_addr_q == `IOBC_OFF_STATUS);
	wire hit_cnt  = (aw_addr_q == `IOBC_OFF_COUNT);
	wire wr_ok    = hit_ctrl || hit_tmo || hit_st || hit_cnt;
	assign st_clr = do_wr && hit_st
		&& (w_data_q[`IOBC_ST_TMO_BIT] & wmask[`IOBC_ST_TMO_BIT]);
	wire [31:0] ctrl_new = (ctrl_q & ~wmask) | (w_data_q & wmask);
	wire [31:0] tmo_new  = (tmo_lim_q & ~wmask) | (w_data_q & wmask);

	// status word: live sequencer state
	logic [31:0] status_w;
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`IOBC_ST_VALID_BIT] = valid_q;
		status_w[`IOBC_ST_RECOVERY_HOLD_BIT] = rec_q;
		status_w[`IOBC_ST_TMO_BIT]   = tmo_flag_q;
		status_w[`IOBC_ST_CNT_MSB:`IOBC_ST_CNT_LSB] = cnt_q;
		status_w[`IOBC_ST_SEL_MSB:`IOBC_ST_SEL_LSB] = sel_eff;
	end
	wire r_ctrl = (s_axi_araddr == `IOBC_OFF_CTRL);
	wire r_tmo  = (s_axi_araddr == `IOBC_OFF_TIMEOUT);
	wire r_st   = (s_axi_araddr == `IOBC_OFF_STATUS);
	wire r_cnt  = (s_axi_araddr == `IOBC_OFF_COUNT);
	wire [31:0] rd_mux = r_ctrl ? ctrl_q : r_tmo ? tmo_lim_q : r_st ? status_w
		: r_cnt ? {16'h0000, cyc_done_q} : 32'h0000_0000;
	wire rd_ok  = r_ctrl || r_tmo || r_st || r_cnt;

	// write channel: address and data in either order, answer after both
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awr_q     <= 1'b1;
			wr_q_rdy  <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bv_q      <= 1'b0;
			bresp_q   <= `IOBC_RESP_OKAY;
			ctrl_q    <= `IOBC_CTRL_RST;
			tmo_lim_q <= `IOBC_TMO_RST;
		end else begin
			if (aw_fire) begin
				aw_hold_q <= 1'b1;
				awr_q     <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_hold_q <= 1'b1;
				wr_q_rdy <= 1'b0;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bv_q      <= 1'b1;
				bresp_q   <= wr_ok ? `IOBC_RESP_OKAY : `IOBC_RESP_SLVERR;
				if (hit_ctrl)
					ctrl_q <= ctrl_new;
				if (hit_tmo)
					tmo_lim_q <= {16'h0000, tmo_new[`IOBC_TMO_MSB:0]};
			end
			if (bv_q && s_axi_bready) begin
				bv_q     <= 1'b0;
				awr_q    <= 1'b1;
				wr_q_rdy <= 1'b1;
			end
		end
	end

	// read channel: one read at a time
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			arr_q   <= 1'b1;
			rv_q    <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `IOBC_RESP_OKAY;
		end else if (ar_fire) begin
			arr_q   <= 1'b0;
			rv_q    <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_ok ? `IOBC_RESP_OKAY : `IOBC_RESP_SLVERR;
		end else if (rv_q && s_axi_rready) begin
			rv_q  <= 1'b0;
			arr_q <= 1'b1;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready        = awr_q;
	assign s_axi_wready         = wr_q_rdy;
	assign s_axi_bvalid         = bv_q;
	assign s_axi_bresp          = bresp_q;
	assign s_axi_arready        = arr_q;
	assign s_axi_rvalid         = rv_q;
	assign s_axi_rdata          = rdata_q;
	assign s_axi_rresp          = rresp_q;
	assign cpu_ready_n          = rdy_n_q;
	assign io_cycle_valid       = valid_q;
	assign io_read_strobe_n     = rd_n_q;
	assign io_write_strobe_n    = wr_n_q;
	assign wait_counter_bits    = cnt_q;
	assign recovery_hold        = rec_q;
	assign xcvr_direction       = dir_q;
	assign xcvr_output_enable_n = den_n_q;
	assign decoder_enable_low_a = dla_q;
	assign decoder_enable_high  = dhi_q;
	assign decoder_enable_low_b = dlb_q;
	assign io_select_n          = sel_n_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire tmo_far = (tmo_lim == 16'h0000) || (tmo_lim > 16'h0010);
	wire fast_go = take && !hold_next && tmo_far;

	chk_zero_wait_two: assert property (fast_go && sel_eff == 3'h0 |=>
		!cpu_ready_n ##1 cpu_ready_n) else $error("zero wait cycle not two clocks");
	chk_wait_extends: assert property (fast_go && sel_eff == 3'h3 |=>
		cpu_ready_n [*3] ##1 !cpu_ready_n) else $error("wait states miscounted");
	chk_ready_second: assert property (fast_go && sel_eff == 3'h0 |=>
		!cpu_ready_n && io_cycle_valid) else $error("ready not in second clock");
	chk_valid_on_start: assert property (take |=> io_cycle_valid)
		else $error("cycle valid not set after strobe");
	chk_end_releases: assert property (cyc_end |=> io_read_strobe_n &&
		io_write_strobe_n && !io_cycle_valid) else $error("strobe held after ready");
	chk_read_no_recovery_hold: assert property ($fell(io_read_strobe_n) |->
		!recovery_hold && io_cycle_valid) else $error("read strobe during recovery");
	chk_counter_idle: assert property (!io_cycle_valid |->
		wait_counter_bits == 3'h0) else $error("counter not zero when idle");
	chk_counter_step: assert property (in_run && cpu_ready_n |=>
		wait_counter_bits == $past(wait_counter_bits) + 3'h1) else $error("counter stalled");
	chk_select_onehot: assert property ((!decoder_enable_low_a && decoder_enable_high
		&& !decoder_enable_low_b) ? $onehot(~io_select_n) : (&io_select_n))
		else $error("decoder select pattern wrong");
	chk_dir_latched: assert property ($rose(io_cycle_valid) |->
		xcvr_direction == $past(cycle_status.write_read_n)) else $error("direction wrong");
	chk_recovery_hold_follows: assert property (cyc_end && rec_len != 8'h00 |=>
		recovery_hold) else $error("no recovery after access");

	cov_zero_wait: cover property (fast_go && sel_eff == 3'h0 ##1 !cpu_ready_n);
	cov_held_start: cover property (in_hold ##1 in_run);
	cov_timeout: cover property (tmo_hit);
	cov_back_to_back: cover property (cyc_end ##[1:8] take);

endmodule : iobc_top

//--- dv/iobc_cpu_model.sv
// Purpose: processor side of the I/O bus, one bus cycle per go pulse
// Assumes: status and address held until ready is sampled
// Notes:   gives up after 40 clocks so ignored cycle types still end
`timescale 1ns/1ps
module iobc_cpu_model
	import iobc_pkg::*;
(
	input  wire logic         clk_sys,        // processor clock
	input  wire logic         go,             // start one cycle
	input  wire iobc_status_t kind,           // cycle type to run
	input  wire logic [7:2]   addr,           // target address
	input  wire logic         cpu_ready_n,    // ready, low
	output logic              addr_strobe_n,  // cycle start, low
	output iobc_status_t      cycle_status,   // cycle type lines
	output logic [7:2]        io_addr,        // address bits
	output logic [3:0]        byte_enables_n, // byte lanes, low
	output logic              busy,           // cycle running
	output int                clocks          // last cycle length
);
	// ==========================================================
	// bus cycle sequencer
	initial begin
		addr_strobe_n = 1'h1;
		cycle_status = 3'h5;
		io_addr = 6'h0;
		byte_enables_n = 4'hf;
		busy = 1'h0;
		clocks = 0;
	end
	always @(posedge clk_sys) begin
		if (go && !busy) begin
			addr_strobe_n <= 1'h0;
			cycle_status <= kind;
			io_addr <= addr;
			byte_enables_n <= 4'h0;
			busy <= 1'h1;
			clocks <= 0;
		end else if (busy) begin
			addr_strobe_n <= 1'h1;
			clocks <= clocks + 1;
			// ready at end of first clock is ignored
			if ((clocks > 0 && cpu_ready_n == 1'h0) || clocks == 40) begin
				busy <= 1'h0;
				cycle_status <= ~cycle_status; // released lines no longer valid
				io_addr <= ~io_addr;
				byte_enables_n <= 4'hf;
			end
		end
	end
endmodule : iobc_cpu_model

//--- dv/testbench.sv
// Purpose: register and bus cycle checks of the I/O bus controller
// Assumes: processor model drives the local bus side
// Notes:   cycle lengths counted from strobe edge to ready edge
`timescale 1ns/1ps
module testbench
	import iobc_pkg::*;
;
	logic clk_sys = 1'h0, rst = 1'h1, go = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, io_select_n, sel_seen;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, byte_enables_n;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic addr_strobe_n, cpu_ready_n, io_cycle_valid, io_read_strobe_n, io_write_strobe_n;
	logic recovery_hold, xcvr_direction, xcvr_output_enable_n, busy;
	logic decoder_enable_low_a, decoder_enable_high, decoder_enable_low_b;
	logic [2:0] wait_count_select = 3'h0, wait_counter_bits;
	logic [7:2] io_addr, tgt = 6'h0;
	iobc_status_t cycle_status, kind = 3'h2;
	logic saw_rd, saw_wr, saw_dir, saw_den, saw_val;
	logic idle_rd = 1'h1;
	int clocks, bad_count = 0, checks = 0, cyc = 0, float_left = 0;
	always #5 clk_sys = ~clk_sys;
	iobc_top dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .addr_strobe_n, .cycle_status, .io_addr, .byte_enables_n,
		.wait_count_select, .cpu_ready_n, .io_cycle_valid, .io_read_strobe_n, .io_write_strobe_n,
		.wait_counter_bits, .recovery_hold, .xcvr_direction, .xcvr_output_enable_n,
		.decoder_enable_low_a, .decoder_enable_high, .decoder_enable_low_b, .io_select_n);
	iobc_cpu_model cpu (.clk_sys, .go, .kind, .addr(tgt), .cpu_ready_n, .addr_strobe_n,
		.cycle_status, .io_addr, .byte_enables_n, .busy, .clocks);
	// ==========================================================
	// cycle monitor and hang limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			conclude();
		end
		if (busy) begin
			saw_rd <= saw_rd | ~io_read_strobe_n;
			saw_wr <= saw_wr | ~io_write_strobe_n;
			saw_dir <= saw_dir | (io_cycle_valid & xcvr_direction);
			saw_den <= saw_den | ~xcvr_output_enable_n;
			saw_val <= saw_val | io_cycle_valid;
			sel_seen <= sel_seen & io_select_n;
		end
		// peripheral keeps the data bus two clocks past the read strobe
		idle_rd <= io_read_strobe_n && io_write_strobe_n;
		if (!io_read_strobe_n) float_left <= 2;
		else if (float_left > 0) float_left <= float_left - 1;
		if (idle_rd && !(io_read_strobe_n && io_write_strobe_n)) chk(float_left, 0);
	end
	// ==========================================================
	// access tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bready <= 1'h0;
				chk(s_axi_bresp, 2'h0);
			end
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rready <= 1'h0;
				chk(s_axi_rdata, d);
				chk(s_axi_rresp, r);
			end
		end while (s_axi_arvalid || s_axi_rready);
	endtask : axi_rd
	task automatic bus(input iobc_status_t k, input logic [7:2] a);
		kind <= k;
		tgt <= a;
		go <= 1'h1;
		{saw_rd, saw_wr, saw_dir, saw_den, saw_val} <= 5'h0;
		sel_seen <= 8'hff;
		@(posedge clk_sys);
		go <= 1'h0;
		do @(posedge clk_sys); while (busy);
	endtask : bus
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	// ==========================================================
	// scenarios
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		chk({io_cycle_valid, cpu_ready_n, io_select_n}, 10'h1ff);
		axi_rd(8'h00, 32'h200, 2'h0);
		axi_rd(8'h04, 32'h100, 2'h0);
		axi_rd(8'h10, 32'h0, 2'h2);
		for (int n = 0; n < 8; n++) begin
			axi_wr(8'h00, 32'h8 | n);
			bus(3'h2, {3'h7, n[2:0]});
			chk(clocks, 2 + n);
			chk({saw_rd, saw_wr, saw_dir, saw_den}, 4'h9);
			chk(sel_seen, 8'(~(8'h1 << n)));
		end
		axi_rd(8'h0c, 32'h8, 2'h0);
		axi_wr(8'h00, 32'h8);
		bus(3'h3, 6'h3c);
		chk(clocks, 2);
		chk({saw_rd, saw_wr, saw_dir, saw_den, sel_seen}, 12'h7ef);
		bus(3'h3, 6'h1c);
		chk(sel_seen, 8'hff);
		bus(3'h6, 6'h3c);
		chk({saw_val, sel_seen}, 9'hff);
		wait_count_select <= 3'h2;
		axi_wr(8'h00, 32'h0);
		bus(3'h2, 6'h38);
		chk(clocks, 4);
		axi_wr(8'h00, 32'h808);
		bus(3'h2, 6'h38);
		chk(recovery_hold, 1'h1);
		bus(3'h2, 6'h38);
		chk(clocks > 2, 1'h1);
		axi_wr(8'h00, 32'h18);
		bus(3'h2, 6'h38);
		chk(sel_seen, 8'hff);
		axi_wr(8'h04, 32'h4);
		axi_wr(8'h00, 32'hf);
		bus(3'h2, 6'h38);
		chk(clocks, 7);
		axi_rd(8'h08, 32'h704, 2'h0);
		axi_wr(8'h08, 32'h4);
		axi_rd(8'h08, 32'h700, 2'h0);
		conclude();
	end
endmodule : testbench
